//--- hdl/wdc_pkg.sv
// Constants shared by the watchdog control block
package wdc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [5:0] WDC_CTRL_ADDR   = 6'h21;
    localparam logic [5:0] WDC_STATUS_ADDR = 6'h34;
    localparam logic [7:0] WDC_CTRL_RESET  = 8'h00;
    localparam int         WDC_UNLOCK_BIT  = 4;
    localparam int         WDC_ENABLE_BIT  = 3;
    localparam int         WDC_SEL_MSB     = 2;
    localparam int         WDC_SEL_W       = 3;
    localparam int         WDC_FLAG_BIT    = 3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int         WDC_CLK_HZ      = 50_000_000;
    localparam int         WDC_OSC_HZ      = 1_000_000;
    localparam int         WDC_OSC_DIV     = WDC_CLK_HZ / WDC_OSC_HZ;
    localparam int         WDC_DIV_W       = 6;
    localparam logic [2:0] WDC_UNLOCK_CYC  = 3'h4;
    localparam int         WDC_BASE_TICKS  = 16_384;
    localparam int         WDC_CNT_W       = 22;

    // ************************************************************
    // Safety levels
    // ************************************************************
    typedef enum logic [1:0] {
        WDC_LVL0,
        WDC_LVL1,
        WDC_LVL2
    } wdc_level_e;

endpackage

//--- hdl/wdc_expiry_counter.sv
// Watchdog oscillator tick divider and expiry counter
`timescale 1ns/100ps
module wdc_expiry_counter
    import wdc_pkg::*;
#(
    parameter int BASE_TICKS = WDC_BASE_TICKS,
    parameter int OSC_DIV    = WDC_OSC_DIV
) (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_n_i,
    // Control
    input  wire logic                 run_i,
    input  wire logic                 restart_i,
    input  wire logic [WDC_SEL_W-1:0] select_i,
    // Expiry
    output logic                      expire_o
);

    typedef struct packed {
        logic [WDC_DIV_W-1:0] div;
        logic [WDC_CNT_W-1:0] cnt;
        logic                 expire;
    } wdc_cnt_s;

    wdc_cnt_s             s;
    wdc_cnt_s             next_s;
    logic                 tick;
    logic [WDC_CNT_W-1:0] limit;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s        = s;
        next_s.expire = 1'b0;
        tick          = (s.div == WDC_DIV_W'(OSC_DIV - 1));
        limit         = WDC_CNT_W'(BASE_TICKS) << select_i;
        next_s.div    = tick ? '0 : s.div + WDC_DIV_W'(1);
        if (!run_i || restart_i) begin
            next_s.cnt = '0;
        end else if (tick) begin
            if (s.cnt >= limit - WDC_CNT_W'(1)) begin
                next_s.cnt    = '0;
                next_s.expire = 1'b1;
            end else begin
                next_s.cnt = s.cnt + WDC_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign expire_o = s.expire;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_stopped_quiet: assert property (!run_i |=> !expire_o && s.cnt == '0)
        else $error("counter ran while stopped");
    a_restart_zero: assert property (restart_i |=> s.cnt == '0)
        else $error("kick did not restart count");
    a_tick_spacing: assert property (tick |=> !tick)
        else $error("oscillator tick too fast");
    a_expire_limit: assert property (expire_o |-> $past(tick)
        && $past(s.cnt) >= $past(limit) - WDC_CNT_W'(1))
        else $error("expiry before selected period");
endmodule

//--- hdl/wdc_watchdog_ctrl.sv
// Watchdog control register, timed unlock and chip reset request
// How it works
// - Clearing enable ignored unless unlock bit set
// - Unlock bit self-clears after four cycles
// - Levels 1, 2: timeout changes need unlock
// - Enable write one enables, accepted zero disables
// - Enable clears only while unlock reads one
// - Disable write within four cycles completes
// - Level 2 keeps watchdog always enabled
// - Select 000 is 16384, doubling per code
// - Codes 001-011 give 32K to 128K
// - Codes 100-111 give 256K to 2048K
// - Counter runs from separate 1 MHz tick
// - Kick, disable and reset restart count
// - Expiry resets chip and sets reset flag
// - Fuses pick safety level and start state
`timescale 1ns/100ps
module wdc_watchdog_ctrl
    import wdc_pkg::*;
#(
    parameter int BASE_TICKS = WDC_BASE_TICKS
) (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    // I/O register path
    input  wire logic [5:0] io_addr_i,
    input  wire logic       io_wr_i,
    input  wire logic       io_rd_i,
    input  wire logic [7:0] io_wdata_i,
    output logic      [7:0] io_rdata_o,
    // Fuses and kick
    input  wire logic       compat_fuse_i,
    input  wire logic       always_on_fuse_i,
    input  wire logic       kick_i,
    // Status
    output logic            watchdog_enable_o,
    output logic            watchdog_reset_flag_o,
    output logic            chip_reset_req_o
);

    typedef struct packed {
        logic                 en;
        logic [WDC_SEL_W-1:0] sel;
        logic [2:0]           unlock_cnt;
        logic                 flag;
        logic [7:0]           rdata;
    } wdc_ctrl_s;

    wdc_ctrl_s  s;
    wdc_ctrl_s  next_s;
    wdc_level_e level;
    logic       unlock;
    logic       en_eff;
    logic       wr_ctrl;
    logic       wr_stat;
    logic       unlock_wr;
    logic       expire;

    // ************************************************************
    // Safety level and decode
    // ************************************************************
    always_comb begin
        if (always_on_fuse_i) begin
            level = WDC_LVL2;
        end else if (compat_fuse_i) begin
            level = WDC_LVL0;
        end else begin
            level = WDC_LVL1;
        end
    end

    assign unlock    = (s.unlock_cnt != 3'h0);
    assign en_eff    = s.en || (level == WDC_LVL2);
    assign wr_ctrl   = io_wr_i && (io_addr_i == WDC_CTRL_ADDR);
    assign wr_stat   = io_wr_i && (io_addr_i == WDC_STATUS_ADDR);
    assign unlock_wr = wr_ctrl && io_wdata_i[WDC_UNLOCK_BIT] && io_wdata_i[WDC_ENABLE_BIT];

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s = s;
        if (unlock_wr) begin
            next_s.unlock_cnt = WDC_UNLOCK_CYC;
        end else if (unlock) begin
            next_s.unlock_cnt = s.unlock_cnt - 3'h1;
        end
        if (wr_ctrl) begin
            if (io_wdata_i[WDC_ENABLE_BIT]) begin
                next_s.en = 1'b1;
            end else if (unlock && level != WDC_LVL2) begin
                next_s.en = 1'b0;
            end
            if (level == WDC_LVL0 || unlock) begin
                next_s.sel = io_wdata_i[WDC_SEL_MSB:0];
            end
        end
        if (wr_stat && !io_wdata_i[WDC_FLAG_BIT]) begin
            next_s.flag = 1'b0;
        end
        if (expire) begin
            next_s.flag = 1'b1;
        end
        if (io_rd_i) begin
            if (io_addr_i == WDC_CTRL_ADDR) begin
                next_s.rdata = {3'h0, unlock, en_eff, s.sel};
            end else if (io_addr_i == WDC_STATUS_ADDR) begin
                next_s.rdata = 8'(s.flag) << WDC_FLAG_BIT;
            end else begin
                next_s.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= {1'b0, WDC_SEL_W'(WDC_CTRL_RESET), 3'h0, 1'b0, 8'h00};
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Expiry counter
    // ************************************************************
    wdc_expiry_counter #(
        .BASE_TICKS (BASE_TICKS),
        .OSC_DIV    (WDC_OSC_DIV)
    ) u_counter (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .run_i     (en_eff),
        .restart_i (kick_i),
        .select_i  (s.sel),
        .expire_o  (expire)
    );

    assign io_rdata_o            = s.rdata;
    assign watchdog_enable_o     = en_eff;
    assign watchdog_reset_flag_o = s.flag;
    assign chip_reset_req_o      = expire;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_unlock_opens: assert property (unlock_wr |=> unlock[*4])
        else $error("unlock window not four cycles");
    a_unlock_closes: assert property (unlock_wr ##1 (!unlock_wr)[*4] |=> !unlock)
        else $error("unlock bit did not clear");
    a_locked_enable: assert property (wr_ctrl && !unlock && en_eff |=> en_eff)
        else $error("watchdog disabled without unlock");
    a_enable_write: assert property (wr_ctrl && io_wdata_i[WDC_ENABLE_BIT] |=> en_eff)
        else $error("enable write ignored");
    a_disable_done: assert property (wr_ctrl && !io_wdata_i[WDC_ENABLE_BIT] && unlock
        && level != WDC_LVL2 |=> !en_eff)
        else $error("timed disable failed");
    a_level2_on: assert property (level == WDC_LVL2 |-> watchdog_enable_o
        && (!$past(io_rd_i) || $past(io_addr_i) != WDC_CTRL_ADDR
        || io_rdata_o[WDC_ENABLE_BIT]))
        else $error("level 2 watchdog disabled");
    a_sel_locked: assert property (wr_ctrl && level != WDC_LVL0 && !unlock
        |=> $stable(s.sel))
        else $error("timeout changed while locked");
    a_req_pulse: assert property (chip_reset_req_o
        |=> !chip_reset_req_o && watchdog_reset_flag_o)
        else $error("reset request not one pulse or flag unset");
    a_no_req_off: assert property (!en_eff ##1 !en_eff |-> !chip_reset_req_o)
        else $error("reset request while disabled");

    // ************************************************************
    // Checks: flag, reset request and level 2 enable
    // ************************************************************
    a_flag_set_wins: assert property (expire && wr_stat && !io_wdata_i[WDC_FLAG_BIT]
        |=> watchdog_reset_flag_o)
        else $error("flag clear beat a new expiry");
    a_flag_clears: assert property (wr_stat && !io_wdata_i[WDC_FLAG_BIT] && !expire
        |=> !watchdog_reset_flag_o)
        else $error("flag not cleared by status write");
    a_flag_sticky: assert property (watchdog_reset_flag_o && !wr_stat
        |=> watchdog_reset_flag_o)
        else $error("flag dropped by itself");
    a_req_needs_on: assert property (chip_reset_req_o |-> $past(en_eff))
        else $error("reset request from a stopped watchdog");
    a_kick_quiet: assert property (kick_i |=> !chip_reset_req_o)
        else $error("reset request right after a kick");
    a_level2_keep: assert property (level == WDC_LVL2 && wr_ctrl && unlock
        && !io_wdata_i[WDC_ENABLE_BIT] |=> watchdog_enable_o)
        else $error("level 2 disable sequence took effect");

    // ************************************************************
    // Checks: window, select and read data
    // ************************************************************
    a_window_reload: assert property (unlock_wr |=> s.unlock_cnt == WDC_UNLOCK_CYC)
        else $error("unlock window not reloaded");
    a_window_shut: assert property (!unlock && !unlock_wr |=> !unlock)
        else $error("unlock window opened by itself");
    a_sel_open: assert property (wr_ctrl && (level == WDC_LVL0 || unlock)
        |=> s.sel == $past(io_wdata_i[WDC_SEL_MSB:0]))
        else $error("timeout select write lost");
    a_ctrl_read: assert property (io_rd_i && io_addr_i == WDC_CTRL_ADDR
        |=> io_rdata_o == {3'h0, $past(unlock), $past(en_eff), $past(s.sel)})
        else $error("control read data wrong");
    a_status_read: assert property (io_rd_i && io_addr_i == WDC_STATUS_ADDR
        |=> io_rdata_o == (8'($past(s.flag)) << WDC_FLAG_BIT))
        else $error("status read data wrong");
    a_unmapped_zero: assert property (io_rd_i && io_addr_i != WDC_CTRL_ADDR
        && io_addr_i != WDC_STATUS_ADDR |=> io_rdata_o == 8'h00)
        else $error("unmapped read not zero");

    // ************************************************************
    // Coverage
    // ************************************************************
    c_unlock: cover property (unlock_wr ##[1:4] (wr_ctrl && !io_wdata_i[WDC_ENABLE_BIT]));
    c_expiry: cover property (chip_reset_req_o);
    c_kick:   cover property (en_eff && kick_i);
    c_open_select: cover property (wr_ctrl && level == WDC_LVL0 && !unlock);
    c_flag_clear:  cover property (wr_stat && watchdog_reset_flag_o && !io_wdata_i[WDC_FLAG_BIT]);
endmodule

//--- verification/wdc_watchdog_ctrl_bench.sv
// Self-checking bench for the watchdog control block
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("BAD %0t mismatch got %h want %h", $time, a, b); end end
module wdc_watchdog_ctrl_bench
    import wdc_pkg::*;
;
    // ****************************************
    // Signals and design
    // ****************************************
    localparam logic [5:0] ctl_a = WDC_CTRL_ADDR;
    localparam logic [5:0] sts_a = WDC_STATUS_ADDR;
    logic        ref_clk_i, reset_n_i, io_wr_i, io_rd_i, kick_i;
    logic        compat_fuse_i, always_on_fuse_i, m_en, m_flag;
    logic        watchdog_enable_o, watchdog_reset_flag_o, chip_reset_req_o;
    logic [5:0]  io_addr_i, a;
    logic [7:0]  io_wdata_i, io_rdata_o, m_rexp, d;
    logic [2:0]  m_sel;
    logic [31:0] v;
    int          err_count = 0, cmp_count = 0, cyc_n = 0, req_n = 0;
    int          req_t, m_cnt, lv, seed, t0, n0, lim;

    wdc_watchdog_ctrl #(.BASE_TICKS(4)) wdc_watchdog_ctrl_inst (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .io_addr_i(io_addr_i),
        .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
        .io_rdata_o(io_rdata_o), .compat_fuse_i(compat_fuse_i),
        .always_on_fuse_i(always_on_fuse_i), .kick_i(kick_i),
        .watchdog_enable_o(watchdog_enable_o),
        .watchdog_reset_flag_o(watchdog_reset_flag_o),
        .chip_reset_req_o(chip_reset_req_o));

    initial begin
        ref_clk_i = 0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // ****************************************
    // Reference model and monitor
    // ****************************************
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            m_en = 0;
            m_cnt = 0;
            m_sel = 0;
            m_flag = 0;
        end else begin
            if (io_rd_i)
                m_rexp = (io_addr_i == ctl_a) ? {3'h0, m_cnt != 0, m_en | (lv == 2), m_sel}
                       : (io_addr_i == sts_a) ? {4'h0, m_flag, 3'h0} : 8'h00;
            if (io_wr_i && io_addr_i == sts_a && !io_wdata_i[3])
                m_flag = 0;
            if (io_wr_i && io_addr_i == ctl_a) begin
                if (lv == 0 || m_cnt != 0) m_sel = io_wdata_i[2:0];
                m_en = io_wdata_i[3] | (m_en & (m_cnt == 0));
            end
            if (io_wr_i && io_addr_i == ctl_a && io_wdata_i[4] && io_wdata_i[3])
                m_cnt = 4;
            else if (m_cnt > 0)
                m_cnt = m_cnt - 1;
        end
    end

    always @(posedge ref_clk_i) begin
        cyc_n++;
        if (chip_reset_req_o === 1'b1) begin
            req_n++;
            req_t = cyc_n;
        end
        if (cyc_n == 90000) begin
            err_count++;
            end_of_test;
        end
    end

    // ****************************************
    // Tasks and sequence
    // ****************************************
    task cyc(input int n);
        io_wr_i = 0;
        io_rd_i = 0;
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task wr(input logic [5:0] ad, input logic [7:0] dt);
        io_addr_i = ad;
        io_wdata_i = dt;
        io_rd_i = 0;
        io_wr_i = 1;
        @(posedge ref_clk_i);
        #1;
        `CHK(watchdog_enable_o, m_en | (lv == 2))
    endtask

    task rd(input logic [5:0] ad);
        io_addr_i = ad;
        io_wr_i = 0;
        io_rd_i = 1;
        @(posedge ref_clk_i);
        #1;
        `CHK(io_rdata_o, m_rexp)
        `CHK(watchdog_reset_flag_o, m_flag)
    endtask

    task rst(input logic cf, input logic ao);
        reset_n_i = 0;
        io_wr_i = 0;
        io_rd_i = 0;
        compat_fuse_i = cf;
        always_on_fuse_i = ao;
        lv = ao ? 2 : cf ? 0 : 1;
        repeat (8) @(posedge ref_clk_i);
        #1;
        reset_n_i = 1;
        cyc(1);
        `CHK(watchdog_enable_o, ao)
        rd(ctl_a);
    endtask

    task end_of_test;
        $display("Counts: errors %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        io_addr_i = 0;
        io_wdata_i = 0;
        kick_i = 0;
        seed = 82680;
        rst(1'b0, 1'b0);
        for (int k = 0; k < 8; k++) begin
            lim = (4 << k) * 50;
            wr(ctl_a, 8'h18);
            wr(ctl_a, 8'h00);
            wr(ctl_a, 8'h08);
            t0 = cyc_n;
            wr(ctl_a, 8'h18);
            wr(ctl_a, {5'h01, k[2:0]});
            cyc(1);
            n0 = req_n;
            if (k % 3 != 0) cyc(lim / 2);
            if (k % 3 == 1) begin
                kick_i = 1;
                cyc(1);
                kick_i = 0;
                t0 = cyc_n;
            end
            if (k % 3 == 2) begin
                wr(ctl_a, 8'h18);
                wr(ctl_a, {5'h00, k[2:0]});
                wr(ctl_a, {5'h01, k[2:0]});
                t0 = cyc_n;
            end
            for (int i = 0; i < lim + 100 && req_n == n0; i++) cyc(1);
            `CHK(req_n, n0 + 1)
            `CHK(req_t - t0 >= lim - 55 && req_t - t0 <= lim + 10, 1'b1)
            cyc(2);
            `CHK(req_n, n0 + 1)
            m_flag = 1;
            rd(sts_a);
            wr(sts_a, 8'h00);
            rd(sts_a);
        end
        for (int f = 0; f < 4; f++) begin
            rst(f[0], f[1]);
            for (int g = 1; g < 6; g++) begin
                wr(ctl_a, 8'h08);
                cyc(1);
                wr(ctl_a, 8'h18);
                if (g > 1) cyc(g - 1);
                wr(ctl_a, 8'h00);
                cyc(1);
            end
            kick_i = 1;
            repeat (60) begin
                v = $random(seed);
                a = (v[1:0] == 0) ? 6'h00 : v[1] ? ctl_a : sts_a;
                d = v[15:8] | (v[4] ? 8'h18 : 8'h00);
                if (v[3]) wr(a, d);
                else rd(a);
                if (v[2]) cyc(1);
            end
            kick_i = 0;
            cyc(1);
        end
        end_of_test;
    end
endmodule
